// ---- design/usrb_rx_fifo.sv ----
// Small receive FIFO held in registers, with flush.
`timescale 1ns/10ps
module usrb_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  full,
  output logic                  empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             do_push;
  logic             do_pop;

  assign full    = (count_q == FULL_CNT);
  assign empty   = (count_q == '0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign rd_data = mem_q[rd_ptr_q];

  always_ff @(posedge mclk) begin
    if (do_push && !flush) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : usrb_rx_fifo

// ---- design/usrb_top.sv ----
// Serial channel data port, status flags, receive FIFO and address filter.
// Rules for this block and the software that drives it
// R1: With the filter bit set, non-address frames are dropped, no buffer, no flag.
// R2: Frame type comes from first stop bit, or from the ninth bit in 9-bit mode.
// R3: Frame type one means address frame, zero means data frame.
// R4: Transmitter ignores the filter bit; only reception filters.
// R5: A 9-bit master sets the ninth bit for addresses, clears it for data.
// R6: Slave software clears the filter when addressed and sets it after the data.
// R7: Senders of 5- to 8-bit filtered traffic use two stop bits.
// R8: Software avoids bit-wise read-modify-write on the filter bit location.
// R9: One data-port address: writes fill transmit buffer, reads give receive data.
// R10: Unused upper bits of short characters are dropped on send, zero on receive.
// R11: Data-port writes while transmit buffer is full are ignored.
// R12: Enabled transmitter loads buffer into empty shifter and shifts it out.
// R13: Two-entry receive FIFO advances on every data-port read.
// R14: Receive-complete shows unread data; receiver disable flushes the FIFO.
// R15: Transmit-complete sets after last frame leaves idle; write one clears it.
// R16: Transmit-buffer-empty shows room for data and is one after reset.
// R17: Frame error describes the head character until it is read.
// R18: Overrun sets on start bit with FIFO and shifter full; held until read.
// R19: Parity error, when checking was on, describes the head character.
// R20: Double speed cuts divisor from 16 to 8, asynchronous mode only.
// R21: Software reads the received ninth bit before the low data bits.
// R22: Software writes the transmit ninth bit before the low data bits.
// R23: Each FIFO entry keeps its own frame error, parity error and ninth bit.
`timescale 1ns/10ps
module usrb_top #(
  parameter int RX_DEPTH = usrb_pkg::RX_DEPTH
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic [usrb_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [usrb_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [usrb_pkg::DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        baud_tick,
  input  wire logic                        rx_frame_valid,
  input  wire logic [8:0]                  rx_frame_data,
  input  wire logic                        rx_frame_stop1,
  input  wire logic                        rx_frame_parity_bad,
  input  wire logic                        rx_start_det,
  output logic                             tx_serial,
  output logic                             rx_enable,
  output logic                             rx_half_rate,
  output logic      [2:0]                  rx_char_size
);
  logic [usrb_pkg::DATA_W-1:0] readdata_q;
  logic                        wait_q;
  logic                        wr_ack;
  logic                        rd_ack;
  logic [7:0]                  rd_byte;
  logic [7:0]                  wbyte;
  logic                        multi_proc_filter_q;
  logic                        double_speed_q;
  logic                        tx_complete_q;
  logic                        rx_en_q;
  logic                        tx_en_q;
  logic [2:0]                  char_size_sel_q;
  logic                        tx_ninth_bit_q;
  logic                        sync_mode_q;
  logic [1:0]                  parity_mode_q;
  logic                        stop_bits_sel_q;
  logic                        overrun_err_q;
  logic                        half_rate_q;
  logic [7:0]                  size_mask;
  logic [3:0]                  n_bits;
  logic                        nine_mode;
  logic                        frame_type;
  logic                        rx_accept;
  logic [usrb_pkg::RXE_W-1:0]  rx_entry;
  logic                        rx_pend_q;
  logic [usrb_pkg::RXE_W-1:0]  rx_pend_data_q;
  logic                        fifo_push;
  logic                        fifo_pop;
  logic                        fifo_full;
  logic                        fifo_empty;
  logic [usrb_pkg::RXE_W-1:0]  head;
  logic                        rx_complete;
  logic                        frame_err;
  logic                        parity_err;
  logic                        rx_ninth_bit;
  logic [8:0]                  tx_holding_buffer_q;
  logic                        tx_full_q;
  logic                        tx_buffer_empty;
  logic                        tx_busy_q;
  logic [usrb_pkg::FRAME_W-1:0] tx_shift_q;
  logic [3:0]                  tx_bits_q;
  logic [4:0]                  tx_tick_q;
  logic                        tx_serial_q;
  logic [4:0]                  div;
  logic                        tx_load;
  logic                        tx_bit_end;
  logic                        tx_done;
  logic [usrb_pkg::FRAME_W-1:0] frame_vec;
  logic [3:0]                  frame_len;
  assign wr_ack = avs_write && !wait_q && avs_byteenable[0];
  assign rd_ack = avs_read && !wait_q;
  assign wbyte  = avs_writedata[7:0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign nine_mode = (char_size_sel_q == usrb_pkg::CS_NINE);
  assign n_bits    = nine_mode ? usrb_pkg::NINE_BITS
                               : usrb_pkg::CS_BASE_BITS + {2'b00, char_size_sel_q[1:0]};
  assign size_mask = nine_mode ? 8'hff : 8'(8'hff >> (4'h8 - n_bits));
  assign rx_complete     = !fifo_empty; // [R14]
  assign frame_err       = !fifo_empty && head[usrb_pkg::RXE_FE]; // [R17]
  assign parity_err      = !fifo_empty && head[usrb_pkg::RXE_PE]; // [R19]
  assign rx_ninth_bit    = !fifo_empty && head[8];
  assign tx_buffer_empty = !tx_full_q; // [R16]

  always_comb begin
    rd_byte = 8'h00;
    unique case (avs_address)
      usrb_pkg::OFS_DATA_PORT: rd_byte = head[7:0]; // [R9]
      usrb_pkg::OFS_STATUS_A: begin
        rd_byte[usrb_pkg::SA_RXC] = rx_complete;
        rd_byte[usrb_pkg::SA_TXC] = tx_complete_q;
        rd_byte[usrb_pkg::SA_TBE] = tx_buffer_empty;
        rd_byte[usrb_pkg::SA_FE]  = frame_err;
        rd_byte[usrb_pkg::SA_DOR] = overrun_err_q;
        rd_byte[usrb_pkg::SA_PE]  = parity_err;
        rd_byte[usrb_pkg::SA_DBL] = double_speed_q;
        rd_byte[usrb_pkg::SA_MPF] = multi_proc_filter_q;
      end
      usrb_pkg::OFS_CTRL_B: begin
        rd_byte[usrb_pkg::CB_RXEN] = rx_en_q;
        rd_byte[usrb_pkg::CB_TXEN] = tx_en_q;
        rd_byte[usrb_pkg::CB_CS2]  = char_size_sel_q[2];
        rd_byte[usrb_pkg::CB_RX9]  = rx_ninth_bit;
        rd_byte[usrb_pkg::CB_TX9]  = tx_ninth_bit_q;
      end
      usrb_pkg::OFS_CTRL_C: begin
        rd_byte[usrb_pkg::CC_SYNC]  = sync_mode_q;
        rd_byte[usrb_pkg::CC_PM_HI] = parity_mode_q[1];
        rd_byte[usrb_pkg::CC_PM_LO] = parity_mode_q[0];
        rd_byte[usrb_pkg::CC_STOP2] = stop_bits_sel_q;
        rd_byte[usrb_pkg::CC_CS_HI] = char_size_sel_q[1];
        rd_byte[usrb_pkg::CC_CS_LO] = char_size_sel_q[0];
      end
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      readdata_q <= '0;
    end else if (avs_read && wait_q) begin
      readdata_q <= {24'h000000, rd_byte};
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      multi_proc_filter_q <= usrb_pkg::RST_STATUS_A[usrb_pkg::SA_MPF];
      double_speed_q      <= usrb_pkg::RST_STATUS_A[usrb_pkg::SA_DBL];
    end else if (wr_ack && avs_address == usrb_pkg::OFS_STATUS_A) begin
      multi_proc_filter_q <= wbyte[usrb_pkg::SA_MPF];
      double_speed_q      <= wbyte[usrb_pkg::SA_DBL];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_en_q            <= usrb_pkg::RST_CTRL_B[usrb_pkg::CB_RXEN];
      tx_en_q            <= usrb_pkg::RST_CTRL_B[usrb_pkg::CB_TXEN];
      char_size_sel_q[2] <= usrb_pkg::RST_CTRL_B[usrb_pkg::CB_CS2];
      tx_ninth_bit_q     <= usrb_pkg::RST_CTRL_B[usrb_pkg::CB_TX9];
    end else if (wr_ack && avs_address == usrb_pkg::OFS_CTRL_B) begin
      rx_en_q            <= wbyte[usrb_pkg::CB_RXEN];
      tx_en_q            <= wbyte[usrb_pkg::CB_TXEN];
      char_size_sel_q[2] <= wbyte[usrb_pkg::CB_CS2];
      tx_ninth_bit_q     <= wbyte[usrb_pkg::CB_TX9];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_mode_q          <= usrb_pkg::RST_CTRL_C[usrb_pkg::CC_SYNC];
      parity_mode_q        <= usrb_pkg::RST_CTRL_C[usrb_pkg::CC_PM_HI:usrb_pkg::CC_PM_LO];
      stop_bits_sel_q      <= usrb_pkg::RST_CTRL_C[usrb_pkg::CC_STOP2];
      char_size_sel_q[1:0] <= usrb_pkg::RST_CTRL_C[usrb_pkg::CC_CS_HI:usrb_pkg::CC_CS_LO];
    end else if (wr_ack && avs_address == usrb_pkg::OFS_CTRL_C) begin
      sync_mode_q          <= wbyte[usrb_pkg::CC_SYNC];
      parity_mode_q        <= wbyte[usrb_pkg::CC_PM_HI:usrb_pkg::CC_PM_LO];
      stop_bits_sel_q      <= wbyte[usrb_pkg::CC_STOP2];
      char_size_sel_q[1:0] <= wbyte[usrb_pkg::CC_CS_HI:usrb_pkg::CC_CS_LO];
    end
  end

  // Only a written one clears the completion flag; a new completion wins.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_complete_q <= usrb_pkg::RST_STATUS_A[usrb_pkg::SA_TXC];
    end else if (tx_done && !tx_full_q) begin
      tx_complete_q <= 1'b1; // [R15]
    end else if (wr_ack && avs_address == usrb_pkg::OFS_STATUS_A
                 && wbyte[usrb_pkg::SA_TXC]) begin
      tx_complete_q <= 1'b0; // [R15]
    end
  end
  assign frame_type = nine_mode ? rx_frame_data[8] : rx_frame_stop1; // [R2]
  assign rx_accept  = rx_en_q && rx_frame_valid
                      && (!multi_proc_filter_q || frame_type); // [R1] [R3]
  assign rx_entry   = {rx_frame_parity_bad && parity_mode_q[1], // [R19]
                       !rx_frame_stop1,                         // [R17]
                       nine_mode && rx_frame_data[8],
                       rx_frame_data[7:0] & size_mask};         // [R10] [R23]

  always_ff @(posedge mclk) begin
    if (srst || !rx_en_q) begin
      rx_pend_q      <= 1'b0;
      rx_pend_data_q <= '0;
    end else if (rx_accept) begin
      rx_pend_q      <= 1'b1;
      rx_pend_data_q <= rx_entry;
    end else if (fifo_push) begin
      rx_pend_q      <= 1'b0;
    end
  end

  assign fifo_push = rx_pend_q && !fifo_full;
  assign fifo_pop  = rd_ack && avs_address == usrb_pkg::OFS_DATA_PORT; // [R13]

  usrb_rx_fifo #(
    .WIDTH (usrb_pkg::RXE_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .mclk    (mclk),
    .srst    (srst),
    .flush   (!rx_en_q), // [R14]
    .push    (fifo_push),
    .wr_data (rx_pend_data_q),
    .pop     (fifo_pop), // [R13]
    .rd_data (head),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );
  always_ff @(posedge mclk) begin
    if (srst || !rx_en_q) begin
      overrun_err_q <= 1'b0;
    end else if (rx_start_det && fifo_full && rx_pend_q) begin
      overrun_err_q <= 1'b1; // [R18]
    end else if (fifo_pop) begin
      overrun_err_q <= 1'b0; // [R18]
    end
  end
  assign div = (double_speed_q && !sync_mode_q) ? usrb_pkg::DIV_DOUBLE
                                                 : usrb_pkg::DIV_NORMAL; // [R20]

  always_ff @(posedge mclk) begin
    if (srst) begin
      half_rate_q <= 1'b0;
    end else begin
      half_rate_q <= double_speed_q && !sync_mode_q; // [R20]
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_full_q           <= 1'b0; // [R16]
      tx_holding_buffer_q <= '0;
    end else if (wr_ack && avs_address == usrb_pkg::OFS_DATA_PORT && !tx_full_q) begin
      tx_full_q           <= 1'b1; // [R9] [R11] [R4]
      tx_holding_buffer_q <= {nine_mode && tx_ninth_bit_q, wbyte & size_mask}; // [R10]
    end else if (tx_load) begin
      tx_full_q           <= 1'b0;
    end
  end
  always_comb begin
    frame_vec    = '1;
    frame_vec[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n_bits) begin
        frame_vec[i + 1] = tx_holding_buffer_q[i];
      end
    end
    if (parity_mode_q[1]) begin
      frame_vec[n_bits + 4'h1] = (^tx_holding_buffer_q) ^ parity_mode_q[0];
    end
    frame_len = 4'h1 + n_bits + {3'b000, parity_mode_q[1]}
                + (stop_bits_sel_q ? 4'h2 : 4'h1);
  end

  assign tx_load    = (tx_en_q || tx_busy_q) && tx_full_q && !tx_busy_q; // [R12]
  assign tx_bit_end = tx_busy_q && baud_tick && (tx_tick_q == div - 5'h01);
  assign tx_done    = tx_bit_end && (tx_bits_q == 4'h1);

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_busy_q   <= 1'b0;
      tx_shift_q  <= '1;
      tx_bits_q   <= '0;
      tx_tick_q   <= '0;
      tx_serial_q <= 1'b1;
    end else if (tx_load) begin
      tx_busy_q   <= 1'b1; // [R12]
      tx_shift_q  <= frame_vec;
      tx_bits_q   <= frame_len;
      tx_tick_q   <= '0;
      tx_serial_q <= frame_vec[0];
    end else if (tx_done) begin
      tx_busy_q   <= 1'b0;
      tx_serial_q <= 1'b1;
    end else if (tx_bit_end) begin
      tx_shift_q  <= {1'b1, tx_shift_q[usrb_pkg::FRAME_W-1:1]}; // [R12]
      tx_serial_q <= tx_shift_q[1];
      tx_bits_q   <= tx_bits_q - 4'h1;
      tx_tick_q   <= '0;
    end else if (tx_busy_q && baud_tick) begin
      tx_tick_q   <= tx_tick_q + 5'h01;
    end
  end

  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = wait_q;
  assign tx_serial       = tx_serial_q;
  assign rx_enable       = rx_en_q;
  assign rx_half_rate    = half_rate_q;
  assign rx_char_size    = char_size_sel_q;
endmodule : usrb_top

// ---- shared/usrb_pkg.sv ----
// Constants shared by the receive-buffer, status and transmit-buffer block.
package usrb_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam logic [3:0]  OFS_DATA_PORT = 4'h0;
  localparam logic [3:0]  OFS_STATUS_A  = 4'h4;
  localparam logic [3:0]  OFS_CTRL_B    = 4'h8;
  localparam logic [3:0]  OFS_CTRL_C    = 4'hc;
  localparam logic [7:0]  RST_STATUS_A  = 8'h20;
  localparam logic [7:0]  RST_CTRL_B    = 8'h00;
  localparam logic [7:0]  RST_CTRL_C    = 8'h06;
  // Status A fields.
  localparam int          SA_RXC        = 7;
  localparam int          SA_TXC        = 6;
  localparam int          SA_TBE        = 5;
  localparam int          SA_FE         = 4;
  localparam int          SA_DOR        = 3;
  localparam int          SA_PE         = 2;
  localparam int          SA_DBL        = 1;
  localparam int          SA_MPF        = 0;
  // Control B fields.
  localparam int          CB_RXEN       = 4;
  localparam int          CB_TXEN       = 3;
  localparam int          CB_CS2        = 2;
  localparam int          CB_RX9        = 1;
  localparam int          CB_TX9        = 0;
  // Control C fields.
  localparam int          CC_SYNC       = 6;
  localparam int          CC_PM_HI      = 5;
  localparam int          CC_PM_LO      = 4;
  localparam int          CC_STOP2      = 3;
  localparam int          CC_CS_HI      = 2;
  localparam int          CC_CS_LO      = 1;
  // Character sizes and baud divisors.
  localparam logic [2:0]  CS_NINE       = 3'h7;
  localparam logic [3:0]  CS_BASE_BITS  = 4'h5;
  localparam logic [3:0]  NINE_BITS     = 4'h9;
  localparam logic [4:0]  DIV_NORMAL    = 5'h10;
  localparam logic [4:0]  DIV_DOUBLE    = 5'h08;
  localparam int          FRAME_W       = 13;
  // Receive entry layout: parity error, frame error, nine data bits.
  localparam int          RXE_W         = 11;
  localparam int          RXE_PE        = 10;
  localparam int          RXE_FE        = 9;
  localparam int          RX_DEPTH      = 2;
endpackage : usrb_pkg

// ---- verification/test_usrb_top.sv ----
// Self-checking bench for the data-port block.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module test_usrb_top;
  logic        mclk           = 1'b0;
  logic        srst           = 1'b1;
  logic [3:0]  avs_address    = 4'h0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rv;
  logic        avs_waitrequest;
  logic        baud_tick, rx_frame_valid, rx_frame_stop1, rx_frame_parity_bad, rx_start_det;
  logic [8:0]  rx_frame_data, dv[3], a;
  logic        tx_serial, rx_enable, rx_half_rate, sv[3], pv[3];
  logic [2:0]  rx_char_size;
  logic [7:0]  seen, seen_cnt, n0, b[3];
  int          compares, error_cnt, seed;
  localparam logic [3:0] DP = usrb_pkg::OFS_DATA_PORT, ST = usrb_pkg::OFS_STATUS_A;
  localparam logic [3:0] CB = usrb_pkg::OFS_CTRL_B, CC = usrb_pkg::OFS_CTRL_C;
  usrb_top i_usrb_top (.mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .baud_tick, .rx_frame_valid,
    .rx_frame_data, .rx_frame_stop1, .rx_frame_parity_bad, .rx_start_det, .tx_serial,
    .rx_enable, .rx_half_rate, .rx_char_size);
  usrb_partner i_usrb_partner (.mclk, .tx_serial, .half_rate(rx_half_rate), .baud_tick,
    .rx_frame_valid, .rx_frame_data, .rx_frame_stop1, .rx_frame_parity_bad, .rx_start_det,
    .seen, .seen_cnt);
  always #2 mclk = ~mclk;
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge mclk);
    avs_read       <= !w;
    avs_write      <= w;
    avs_address    <= ad;
    avs_writedata  <= {24'h0, wd};
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    logic [31:0] v;
    bus(1'b1, ad, d, 4'hf, v);
  endtask : wr
  task automatic rdc(input string nm, input logic [3:0] ad, input logic [7:0] ex,
                     input logic [7:0] m = 8'hff);
    logic [31:0] v;
    bus(1'b0, ad, 8'h00, 4'hf, v);
    `CHK(nm, {24'h0, ex & m}, v & {24'h0, m})
  endtask : rdc
  function automatic logic [7:0] sta(input logic rxc, fe, dor, pe, mpf);
    return {rxc, 1'b0, 1'b1, fe, dor, pe, 1'b0, mpf};
  endfunction : sta
  function automatic logic [7:0] exp_char(input logic [8:0] d, input int sz);
    return d[7:0] & 8'((9'h1 << (5 + sz)) - 9'h1);
  endfunction : exp_char
  initial begin
    seed = $urandom(32'hcc47);
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rdc("status_rst", ST, usrb_pkg::RST_STATUS_A);
    rdc("ctrl_b_rst", CB, usrb_pkg::RST_CTRL_B);
    rdc("ctrl_c_rst", CC, usrb_pkg::RST_CTRL_C);
    rdc("unmapped", 4'h2, 8'h00);
    wr(ST, 8'hbd);
    rdc("status_ro", ST, 8'h21);
    wr(ST, 8'h00);
    bus(1'b1, CC, 8'h00, 4'he, rv);
    rdc("ctrl_c_lane", CC, usrb_pkg::RST_CTRL_C);
    wr(CC, 8'h26);
    wr(CB, 8'h18);
    for (int i = 0; i < 3; i++) begin
      dv[i] = 9'($urandom);
      sv[i] = (i == 1) ? !sv[0] : 1'($urandom);
      pv[i] = (i == 1) ? !pv[0] : 1'($urandom);
    end
    for (int i = 0; i < 2; i++) i_usrb_partner.send(dv[i], sv[i], pv[i]);
    for (int i = 0; i < 2; i++) begin
      rdc("head", ST, sta(1'b1, !sv[i], 1'b0, pv[i], 1'b0));
      rdc("rx_data", DP, dv[i][7:0]);
    end
    rdc("rx_empty", ST, 8'h00, 8'h80);
    for (int i = 0; i < 3; i++) i_usrb_partner.send(dv[i], 1'b1, 1'b0);
    i_usrb_partner.start_pulse();
    for (int i = 0; i < 3; i++) begin
      rdc("overrun", ST, (i == 0) ? 8'h88 : 8'h80, 8'h88);
      rdc("ovr_data", DP, dv[i][7:0]);
    end
    wr(CC, 8'h06);
    for (int m = 0; m < 2; m++) begin
      a = 9'($urandom);
      wr(CB, 8'h18 | {5'h0, m[0], 2'h0});
      wr(ST, 8'h01);
      i_usrb_partner.send({!m[0], a[7:0]}, m[0], 1'b0);
      rdc("filtered", ST, 8'h00, 8'h80);
      i_usrb_partner.send({m[0], a[7:0]}, !m[0], 1'b0);
      rdc("addr_in", ST, 8'h80, 8'h80);
      rdc("ninth", CB, 8'h02, {6'h0, m[0], 1'b0});
      rdc("addr_data", DP, a[7:0]);
      wr(ST, 8'h00);
      i_usrb_partner.send({1'b0, ~a[7:0]}, 1'b0, 1'b0);
      rdc("unfiltered", DP, ~a[7:0]);
    end
    wr(CB, 8'h18);
    for (int sz = 0; sz < 3; sz++) begin
      a = 9'($urandom) | 9'h1e0;
      wr(CC, {5'h0, 2'(sz), 1'b0});
      i_usrb_partner.send(a, 1'b1, 1'b0);
      rdc("short", DP, exp_char(a, sz));
    end
    wr(CC, 8'h06);
    i_usrb_partner.send(a, 1'b1, 1'b0);
    wr(CB, 8'h08);
    i_usrb_partner.send(a, 1'b1, 1'b0);
    rdc("flushed", ST, 8'h00, 8'h80);
    wr(CB, 8'h18);
    rdc("still_empty", ST, 8'h00, 8'h80);
    for (int ds = 0; ds < 2; ds++) begin
      wr(ST, {6'h0, ds[0], 1'b1});
      repeat (2) @(posedge mclk);
      `CHK("half_rate", ds[0], rx_half_rate)
      n0 = seen_cnt;
      for (int k = 0; k < 3; k++) begin
        b[k] = 8'($urandom);
        wr(DP, b[k]);
      end
      rdc("tbe_full", ST, 8'h00, 8'h20);
      wait (seen_cnt == n0 + 8'h01);
      `CHK("tx_first", b[0], seen)
      wait (seen_cnt == n0 + 8'h02);
      `CHK("tx_second", b[1], seen)
      repeat (400) @(posedge mclk);
      `CHK("tx_count", n0 + 8'h02, seen_cnt)
      rdc("tx_done", ST, 8'h60, 8'h60);
      wr(ST, {6'h10, ds[0], 1'b1});
      rdc("txc_clear", ST, 8'h01, 8'h41);
    end
    wrap_up();
  end
endmodule : test_usrb_top

// ---- verification/usrb_assertions.sv ----
// Checker of the bus handshake and mode outputs.
`timescale 1ns/10ps
module usrb_assertions (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire logic [usrb_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [usrb_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        tx_serial,
  input wire logic                        rx_enable,
  input wire logic                        rx_half_rate,
  input wire logic [2:0]                  rx_char_size
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic rd_ans = avs_read && !avs_waitrequest;
  wire logic rd_st  = rd_ans && avs_address == usrb_pkg::OFS_STATUS_A;
  wire logic rd_cc  = rd_ans && avs_address == usrb_pkg::OFS_CTRL_C;
  a_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("wait count");
  a_wait_idle:
    assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("idle answer");
  a_unmapped_zero:
    assert property (rd_ans && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("unmapped read");
  a_upper_zero:
    assert property (rd_ans |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
  a_rx_off_empty:
    assert property (rd_st && !rx_enable && !$past(rx_enable, 4) |->
      !avs_readdata[usrb_pkg::SA_RXC]) else $error("flag while off");
  a_ctrl_b_mirror:
    assert property (rd_ans && avs_address == usrb_pkg::OFS_CTRL_B |->
      avs_readdata[usrb_pkg::CB_CS2] == rx_char_size[2] &&
      avs_readdata[usrb_pkg::CB_RXEN] == rx_enable) else $error("control b");
  a_ctrl_c_mirror:
    assert property (rd_cc |-> avs_readdata[2:1] == rx_char_size[1:0]) else $error("size");
  a_half_rate:
    assert property (rd_st && rx_half_rate |-> avs_readdata[usrb_pkg::SA_DBL])
      else $error("half rate");
  a_sync_full:
    assert property (rd_cc && avs_readdata[usrb_pkg::CC_SYNC] |-> !rx_half_rate)
      else $error("half rate in sync");
  a_tx_idle_reset:
    assert property ($fell(srst) |-> tx_serial [*2]) else $error("line not idle");
  c_data_read: cover property (rd_ans && avs_address == usrb_pkg::OFS_DATA_PORT);
  c_double: cover property ($rose(rx_half_rate));
  c_tx_start: cover property ($fell(tx_serial));
endmodule : usrb_assertions

bind usrb_top usrb_assertions i_usrb_assertions (.mclk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .tx_serial, .rx_enable, .rx_half_rate,
  .rx_char_size);

// ---- verification/usrb_partner.sv ----
// Far-end transceiver model.
`timescale 1ns/10ps
module usrb_partner (
  input  wire logic       mclk,
  input  wire logic       tx_serial,
  input  wire logic       half_rate,
  output logic            baud_tick,
  output logic            rx_frame_valid,
  output logic [8:0]      rx_frame_data,
  output logic            rx_frame_stop1,
  output logic            rx_frame_parity_bad,
  output logic            rx_start_det,
  output logic [7:0]      seen,
  output logic [7:0]      seen_cnt
);
  logic       busy = 1'b0;
  logic [7:0] sh   = 8'h00;
  int         cnt  = 0;
  int         div;
  always_comb div = half_rate ? int'(usrb_pkg::DIV_DOUBLE) : int'(usrb_pkg::DIV_NORMAL);
  initial begin
    baud_tick = 1'b0;
    rx_frame_valid = 1'b0;
    rx_frame_data = 9'h000;
    rx_frame_stop1 = 1'b1;
    rx_frame_parity_bad = 1'b0;
    rx_start_det = 1'b0;
    seen = 8'h00;
    seen_cnt = 8'h00;
  end
  // Samples mid-bit on the ticks the block counts.
  always @(posedge mclk) begin
    baud_tick <= ~baud_tick;
    if (baud_tick && !busy && !tx_serial) begin
      busy <= 1'b1;
      cnt  <= 0;
    end else if (baud_tick && busy) begin
      cnt <= cnt + 1;
      if (cnt % div == div / 2 - 1 && cnt / div == 9) begin
        seen     <= sh;
        seen_cnt <= seen_cnt + 8'h01;
        busy     <= 1'b0;
      end else if (cnt % div == div / 2 - 1 && cnt / div > 0) begin
        sh <= {tx_serial, sh[7:1]};
      end
    end
  end
  task automatic send(input logic [8:0] d, input logic s, input logic p);
    @(posedge mclk);
    rx_frame_valid      <= 1'b1;
    rx_frame_data       <= d;
    rx_frame_stop1      <= s;
    rx_frame_parity_bad <= p;
    @(posedge mclk);
    rx_frame_valid      <= 1'b0;
    rx_frame_data       <= ~d;
    rx_frame_stop1      <= ~s;
    rx_frame_parity_bad <= ~p;
    repeat (3) @(posedge mclk);
  endtask : send
  task automatic start_pulse;
    @(posedge mclk);
    rx_start_det <= 1'b1;
    @(posedge mclk);
    rx_start_det <= 1'b0;
  endtask : start_pulse
endmodule : usrb_partner
